// [hdl/sms_consts.svh]
// Purpose: Offsets, field positions, reset values and counts of the standby sequencer.
// Assumes: Included by bare name from every design file that needs it.
// Notes:   Byte addresses on a 32-bit Avalon-MM slave, one register per word.
`ifndef SMS_CONSTS_SVH
`define SMS_CONSTS_SVH

`define SMS_ADDR_W          8
`define SMS_DATA_W          32
`define SMS_OFS_SYSCTL1     8'h00
`define SMS_OFS_SYSCTL2     8'h04
`define SMS_OFS_TBCTL       8'h08
`define SMS_OFS_KEYWU       8'h0c
`define SMS_OFS_IRQCTL      8'h10
`define SMS_OFS_IRQEN       8'h14
`define SMS_OFS_IRQLAT      8'h18
`define SMS_OFS_STATUS      8'h1c

`define SMS_B1_STOP         7
`define SMS_B1_RELSEL       6
`define SMS_B1_WU_HI        3
`define SMS_B1_WU_LO        2
`define SMS_B1_DIVSEL       0
`define SMS_B2_XEN          7
`define SMS_B2_XTEN         6
`define SMS_B2_SYSCK        5
`define SMS_B2_IDLE         4
`define SMS_B2_TIMING_GEN_HALT       2
`define SMS_BTB_EN          3
`define SMS_BKEY_HI         7
`define SMS_BKEY_LO         4
`define SMS_BIRQ_MASTER     0

`define SMS_RST_WU          2'h0
`define SMS_RST_XEN         1'b1
`define SMS_RST_XTEN        1'b0
`define SMS_RST_KEYWU       4'h0
`define SMS_IRQ_N           16
`define SMS_TB_IRQ_BIT      8

`define SMS_WU_CNT_W        19
`define SMS_WU_NORM_0       196608
`define SMS_WU_NORM_1       65536
`define SMS_WU_NORM_2       49152
`define SMS_WU_NORM_3       16384
`define SMS_WU_SLOW_0       24576
`define SMS_WU_SLOW_1       8192
`define SMS_WU_SLOW_2       192
`define SMS_WU_SLOW_3       64

`endif

// [hdl/sms_pkg.sv]
// Purpose: Types shared by the standby sequencer files.
// Assumes: Nothing beyond the tool's SystemVerilog support.
// Notes:   Constants live in sms_consts.svh.
package sms_pkg;
	typedef enum logic [2:0] {
		SMS_RUN,
		SMS_STOP_WAIT,
		SMS_WARMUP,
		SMS_IDLE12,
		SMS_IDLE0
	} sms_state_t;
endpackage

// [hdl/sms_pin_sync.sv]
// Purpose: Two-flop synchroniser for a pin with edge detection on the settled level.
// Assumes: The pin is asynchronous to clk.
// Notes:   The first flop feeds only the second one.
`timescale 1ns/1ps
`default_nettype none
module sms_pin_sync #(
	parameter logic RST_LEVEL = 1'b1
) (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic pin,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic meta_ff;
	logic sync_ff;
	logic last_ff;

	always_ff @(posedge clk) begin
		if (srst) begin
			meta_ff <= RST_LEVEL;
			sync_ff <= RST_LEVEL;
			last_ff <= RST_LEVEL;
		end else begin
			meta_ff <= pin;
			sync_ff <= meta_ff;
			last_ff <= sync_ff;
		end
	end

	assign level = sync_ff;
	assign rise  = sync_ff & ~last_ff;
	assign fall  = ~sync_ff & last_ff;
endmodule
`default_nettype wire

// [hdl/sms_warmup_counter.sv]
// Purpose: Counts the oscillator warm-up period after a stop exit.
// Assumes: clk stands for the base clock of the oscillator being restarted.
// Notes:   Counts follow the base clock, so the period drifts with the oscillator.
`timescale 1ns/1ps
`default_nettype none
`include "sms_consts.svh"
module sms_warmup_counter #(
	parameter int CW     = `SMS_WU_CNT_W,
	parameter int NORM_0 = `SMS_WU_NORM_0,
	parameter int NORM_1 = `SMS_WU_NORM_1,
	parameter int NORM_2 = `SMS_WU_NORM_2,
	parameter int NORM_3 = `SMS_WU_NORM_3,
	parameter int SLOW_0 = `SMS_WU_SLOW_0,
	parameter int SLOW_1 = `SMS_WU_SLOW_1,
	parameter int SLOW_2 = `SMS_WU_SLOW_2,
	parameter int SLOW_3 = `SMS_WU_SLOW_3
) (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       start,
	input  wire logic [1:0] code,
	input  wire logic       div_sel,
	input  wire logic       slow_ret,
	output logic            busy,
	output logic            done
);
	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] load_val;
	logic          busy_ff;
	logic          done_ff;

	always_comb begin
		load_val = '0;
		unique case ({slow_ret, code})
			3'b000: load_val = CW'(NORM_0);
			3'b001: load_val = CW'(NORM_1);
			3'b010: load_val = CW'(NORM_2);
			3'b011: load_val = CW'(NORM_3);
			3'b100: load_val = CW'(SLOW_0);
			3'b101: load_val = CW'(SLOW_1);
			3'b110: load_val = CW'(SLOW_2);
			3'b111: load_val = CW'(SLOW_3);
		endcase
		if (!slow_ret && div_sel) begin
			load_val = CW'({load_val, 1'b0});
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_ff  <= '0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			if (start) begin
				cnt_ff  <= load_val - CW'(1);
				busy_ff <= 1'b1;
			end else if (busy_ff) begin
				if (cnt_ff == '0) begin
					busy_ff <= 1'b0;
					done_ff <= 1'b1;
				end else begin
					cnt_ff <= cnt_ff - CW'(1);
				end
			end
		end
	end

	assign busy = busy_ff;
	assign done = done_ff;
endmodule
`default_nettype wire

// [hdl/sms_standby_sequencer.sv]
// Purpose: Standby sequencer for stop, idle and sleep modes with an Avalon-MM slave.
// Assumes: All request inputs are on clk; stop, reset and time base pins are asynchronous.
// Notes:   Only the edge-triggered stop exit is built; the release select bit is stored.
// What this block does
// - A rising edge on the active-low stop pin ends stop mode.
// - Stop is entered on command even when the stop pin is high.
// - Stop exit restarts oscillators according to return mode and clock setup.
// - A selectable warm-up of four lengths follows, with everything halted.
// - After warm-up, execution resumes at the instruction after the stop command.
// - Leaving stop clears the timing generator prescaler and divider.
// - A low reset pin ends stop at once with a normal reset.
// - Warm-up figures at 16 MHz and 32.768 kHz; divider select doubles the 16 MHz ones only.
// - Warm-up is a count of base clock cycles and drifts with it.
// - Idle1/2 and sleep1/2 halt CPU and watchdog; peripherals keep running.
// - Memory, registers, status words and port latches stay unchanged in standby.
// - Leaving idle1/2 clears the idle bit and restores the earlier mode.
// - A low reset pin ends any idle or sleep and comes up normal.
// - With master enable off, a wake resumes without service; software clears latch.
// - With master enable on, the waking interrupt is serviced first.
// - A watchdog interrupt just before idle entry is serviced instead of entering.
// - Idle0 and sleep0 stop peripheral clocks except the time base timer.
// - Leaving idle0 clears the halt bit, restores mode, latches time base interrupt if the time base enable is set.
// - A time base source falling edge ends idle0 whatever the enable says.
// - Warm-up codes map to fixed high or low clock cycle counts.
// - With all three enables set, idle0 exit services the time base interrupt.
`timescale 1ns/1ps
`default_nettype none
`include "sms_consts.svh"
module sms_standby_sequencer #(
	parameter int IRQ_N       = `SMS_IRQ_N,
	parameter int WU_NORM_0   = `SMS_WU_NORM_0,
	parameter int WU_NORM_1   = `SMS_WU_NORM_1,
	parameter int WU_NORM_2   = `SMS_WU_NORM_2,
	parameter int WU_NORM_3   = `SMS_WU_NORM_3,
	parameter int WU_SLOW_0   = `SMS_WU_SLOW_0,
	parameter int WU_SLOW_1   = `SMS_WU_SLOW_1,
	parameter int WU_SLOW_2   = `SMS_WU_SLOW_2,
	parameter int WU_SLOW_3   = `SMS_WU_SLOW_3
) (
	input  wire logic                    clk,
	input  wire logic                    srst,
	input  wire logic [`SMS_ADDR_W-1:0]  avs_address,
	input  wire logic                    avs_read,
	input  wire logic                    avs_write,
	input  wire logic [`SMS_DATA_W-1:0]  avs_writedata,
	output logic      [`SMS_DATA_W-1:0]  avs_readdata,
	output logic                         avs_waitrequest,
	input  wire logic                    stop_n_pin,
	input  wire logic                    reset_n_pin,
	input  wire logic                    tb_src_clk_pin,
	input  wire logic [IRQ_N-1:0]        irq_req,
	input  wire logic                    wdt_irq,
	output logic                         cpu_run,
	output logic                         wdt_run,
	output logic                         periph_clk_en,
	output logic                         tbt_clk_en,
	output logic                         hf_osc_en,
	output logic                         lf_osc_en,
	output logic                         sys_clk_low,
	output logic                         tg_clear,
	output logic                         resume_pulse,
	output logic                         irq_service,
	output logic                         chip_reset
);
	sms_pkg::sms_state_t state_ff;
	sms_pkg::sms_state_t nxt_state;

	logic                   rst;
	logic                   pin_rst_n;
	logic                   stop_rise;
	logic                   stop_level;
	logic                   tb_fall;
	logic                   ack_ff;
	logic                   wr_acc;
	logic [`SMS_DATA_W-1:0] rdata_ff;
	logic [1:0]             wu_code_ff;
	logic                   div_sel_ff;
	logic                   rel_sel_ff;
	logic                   xen_ff;
	logic                   xten_ff;
	logic                   sysck_ff;
	logic                   saved_sysck_ff;
	logic                   dual_ff;
	logic                   tb_en_ff;
	logic [3:0]             key_wu_ff;
	logic                   master_en_ff;
	logic [IRQ_N-1:0]       irq_en_ff;
	logic [IRQ_N-1:0]       irq_lat_ff;
	logic                   tg_clear_ff;
	logic                   resume_ff;
	logic                   service_ff;
	logic                   wu_start;
	logic                   wu_done;
	logic                   set_tb;
	logic                   svc;
	logic                   resume;
	logic                   wr_stop;
	logic                   wr_idle;
	logic                   wr_halt;
	logic                   wr_ctl2;
	logic                   wake_any;

	function automatic logic hit(input logic [`SMS_ADDR_W-1:0] a,
		input logic [`SMS_ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction

	sms_pin_sync #(.RST_LEVEL(1'b1)) u_rst_sync (
		.clk   (clk),
		.srst  (srst),
		.pin   (reset_n_pin),
		.level (pin_rst_n),
		.rise  (),
		.fall  ()
	);

	sms_pin_sync #(.RST_LEVEL(1'b1)) u_stop_sync (
		.clk   (clk),
		.srst  (srst),
		.pin   (stop_n_pin),
		.level (stop_level),
		.rise  (stop_rise),
		.fall  ()
	);

	sms_pin_sync #(.RST_LEVEL(1'b0)) u_tb_sync (
		.clk   (clk),
		.srst  (srst),
		.pin   (tb_src_clk_pin),
		.level (),
		.rise  (),
		.fall  (tb_fall)
	);

	// A low reset pin resets the whole sequencer, so every standby ends in normal mode.
	assign rst = srst | ~pin_rst_n;

	sms_warmup_counter #(
		.NORM_0 (WU_NORM_0),
		.NORM_1 (WU_NORM_1),
		.NORM_2 (WU_NORM_2),
		.NORM_3 (WU_NORM_3),
		.SLOW_0 (WU_SLOW_0),
		.SLOW_1 (WU_SLOW_1),
		.SLOW_2 (WU_SLOW_2),
		.SLOW_3 (WU_SLOW_3)
	) u_warmup (
		.clk      (clk),
		.srst     (rst),
		.start    (wu_start),
		.code     (wu_code_ff),
		.div_sel  (div_sel_ff),
		.slow_ret (saved_sysck_ff),
		.busy     (),
		.done     (wu_done)
	);

	// Bus slave: one wait cycle per access, so read data are always from a flop.
	always_ff @(posedge clk) begin
		if (rst) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= (avs_read | avs_write) & ~ack_ff;
		end
	end

	assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
	assign wr_acc          = avs_write & ack_ff;
	// Control writes only count while running; a halted CPU cannot issue them.
	assign wr_ctl2 = wr_acc && hit(avs_address, `SMS_OFS_SYSCTL2) && state_ff == sms_pkg::SMS_RUN;
	assign wr_stop = wr_acc && hit(avs_address, `SMS_OFS_SYSCTL1)
		&& avs_writedata[`SMS_B1_STOP] && state_ff == sms_pkg::SMS_RUN;
	assign wr_idle = wr_ctl2 && avs_writedata[`SMS_B2_IDLE];
	assign wr_halt = wr_ctl2 && avs_writedata[`SMS_B2_TIMING_GEN_HALT];
	assign wake_any = |(irq_lat_ff & irq_en_ff);

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_ff <= 32'h0000_0000;
		end else if (avs_read && !ack_ff) begin
			rdata_ff <= 32'h0000_0000;
			unique case (1'b1)
				hit(avs_address, `SMS_OFS_SYSCTL1): begin
					rdata_ff[`SMS_B1_RELSEL]                  <= rel_sel_ff;
					rdata_ff[`SMS_B1_WU_HI:`SMS_B1_WU_LO]     <= wu_code_ff;
					rdata_ff[`SMS_B1_DIVSEL]                  <= div_sel_ff;
				end
				hit(avs_address, `SMS_OFS_SYSCTL2): begin
					rdata_ff[`SMS_B2_XEN]    <= xen_ff;
					rdata_ff[`SMS_B2_XTEN]   <= xten_ff;
					rdata_ff[`SMS_B2_SYSCK]  <= sysck_ff;
					rdata_ff[`SMS_B2_IDLE]   <= (state_ff == sms_pkg::SMS_IDLE12);
					rdata_ff[`SMS_B2_TIMING_GEN_HALT] <= (state_ff == sms_pkg::SMS_IDLE0);
				end
				hit(avs_address, `SMS_OFS_TBCTL):  rdata_ff[`SMS_BTB_EN] <= tb_en_ff;
				hit(avs_address, `SMS_OFS_KEYWU):
					rdata_ff[`SMS_BKEY_HI:`SMS_BKEY_LO] <= key_wu_ff;
				hit(avs_address, `SMS_OFS_IRQCTL): rdata_ff[`SMS_BIRQ_MASTER] <= master_en_ff;
				hit(avs_address, `SMS_OFS_IRQEN):  rdata_ff[IRQ_N-1:0] <= irq_en_ff;
				hit(avs_address, `SMS_OFS_IRQLAT): rdata_ff[IRQ_N-1:0] <= irq_lat_ff;
				hit(avs_address, `SMS_OFS_STATUS): begin
					rdata_ff[2:0] <= state_ff;
					rdata_ff[3]   <= saved_sysck_ff;
					rdata_ff[4]   <= dual_ff;
					rdata_ff[5]   <= stop_level;
				end
				default: rdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	assign avs_readdata = rdata_ff;

	// Sequencer state.
	always_comb begin
		nxt_state = state_ff;
		wu_start  = 1'b0;
		set_tb    = 1'b0;
		svc       = 1'b0;
		resume    = 1'b0;
		unique case (state_ff)
			sms_pkg::SMS_RUN: begin
				if (wr_stop) begin
					nxt_state = sms_pkg::SMS_STOP_WAIT;
				end else if (wr_idle && wdt_irq) begin
					svc = 1'b1;
				end else if (wr_idle) begin
					nxt_state = sms_pkg::SMS_IDLE12;
				end else if (wr_halt) begin
					nxt_state = sms_pkg::SMS_IDLE0;
				end
			end
			sms_pkg::SMS_STOP_WAIT: begin
				if (stop_rise) begin
					nxt_state = sms_pkg::SMS_WARMUP;
					wu_start  = 1'b1;
				end
			end
			sms_pkg::SMS_WARMUP: begin
				if (wu_done) begin
					nxt_state = sms_pkg::SMS_RUN;
					resume    = 1'b1;
				end
			end
			sms_pkg::SMS_IDLE12: begin
				if (wake_any) begin
					nxt_state = sms_pkg::SMS_RUN;
					resume    = 1'b1;
					svc       = master_en_ff;
				end
			end
			sms_pkg::SMS_IDLE0: begin
				if (tb_fall) begin
					nxt_state = sms_pkg::SMS_RUN;
					resume    = 1'b1;
					set_tb    = tb_en_ff;
					svc       = master_en_ff & irq_en_ff[`SMS_TB_IRQ_BIT] & tb_en_ff;
				end
			end
			default: nxt_state = sms_pkg::SMS_RUN;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= sms_pkg::SMS_RUN;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			tg_clear_ff <= 1'b0;
			resume_ff   <= 1'b0;
			service_ff  <= 1'b0;
		end else begin
			tg_clear_ff <= wu_start;
			resume_ff   <= resume;
			service_ff  <= svc;
		end
	end

	// Software configuration; held untouched through any standby.
	always_ff @(posedge clk) begin
		if (rst) begin
			wu_code_ff   <= `SMS_RST_WU;
			div_sel_ff   <= 1'b0;
			rel_sel_ff   <= 1'b0;
			tb_en_ff     <= 1'b0;
			key_wu_ff    <= `SMS_RST_KEYWU;
			master_en_ff <= 1'b0;
			irq_en_ff    <= '0;
		end else if (wr_acc && state_ff == sms_pkg::SMS_RUN) begin
			if (hit(avs_address, `SMS_OFS_SYSCTL1)) begin
				wu_code_ff <= avs_writedata[`SMS_B1_WU_HI:`SMS_B1_WU_LO];
				div_sel_ff <= avs_writedata[`SMS_B1_DIVSEL];
				rel_sel_ff <= avs_writedata[`SMS_B1_RELSEL];
			end
			if (hit(avs_address, `SMS_OFS_TBCTL)) begin
				tb_en_ff <= avs_writedata[`SMS_BTB_EN];
			end
			if (hit(avs_address, `SMS_OFS_KEYWU)) begin
				key_wu_ff <= avs_writedata[`SMS_BKEY_HI:`SMS_BKEY_LO];
			end
			if (hit(avs_address, `SMS_OFS_IRQCTL)) begin
				master_en_ff <= avs_writedata[`SMS_BIRQ_MASTER];
			end
			if (hit(avs_address, `SMS_OFS_IRQEN)) begin
				irq_en_ff <= avs_writedata[IRQ_N-1:0];
			end
		end
	end

	// Latches: a set in the same cycle as a write-one clear wins.
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_lat_ff <= '0;
		end else begin
			for (int i = 0; i < IRQ_N; i++) begin
				if (irq_req[i] || (set_tb && i == `SMS_TB_IRQ_BIT)) begin
					irq_lat_ff[i] <= 1'b1;
				end else if (wr_acc && hit(avs_address, `SMS_OFS_IRQLAT)
					&& avs_writedata[i]) begin
					irq_lat_ff[i] <= 1'b0;
				end
			end
		end
	end

	// Clock setup: captured at entry, restored at a normal wake.
	always_ff @(posedge clk) begin
		if (rst) begin
			xen_ff         <= `SMS_RST_XEN;
			xten_ff        <= `SMS_RST_XTEN;
			sysck_ff       <= 1'b0;
			saved_sysck_ff <= 1'b0;
			dual_ff        <= 1'b0;
		end else if (state_ff == sms_pkg::SMS_RUN && nxt_state != sms_pkg::SMS_RUN) begin
			saved_sysck_ff <= sysck_ff;
			dual_ff        <= xten_ff;
			if (nxt_state == sms_pkg::SMS_STOP_WAIT) begin
				xen_ff  <= 1'b0;
				xten_ff <= 1'b0;
			end
		end else if (wu_start) begin
			xen_ff  <= ~saved_sysck_ff;
			xten_ff <= saved_sysck_ff | dual_ff;
		end else if (resume) begin
			sysck_ff <= saved_sysck_ff;
		end else if (wr_ctl2) begin
			xen_ff   <= avs_writedata[`SMS_B2_XEN];
			xten_ff  <= avs_writedata[`SMS_B2_XTEN];
			sysck_ff <= avs_writedata[`SMS_B2_SYSCK];
		end
	end

	assign cpu_run       = (state_ff == sms_pkg::SMS_RUN);
	assign wdt_run       = (state_ff == sms_pkg::SMS_RUN);
	assign periph_clk_en = (state_ff == sms_pkg::SMS_RUN) || (state_ff == sms_pkg::SMS_IDLE12);
	assign tbt_clk_en    = periph_clk_en || (state_ff == sms_pkg::SMS_IDLE0);
	assign hf_osc_en     = xen_ff;
	assign lf_osc_en     = xten_ff;
	assign sys_clk_low   = sysck_ff;
	assign tg_clear      = tg_clear_ff;
	assign resume_pulse  = resume_ff;
	assign irq_service   = service_ff;
	assign chip_reset    = rst;
endmodule
`default_nettype wire

// [testbench/sms_standby_sequencer_monitor.sv]
// Purpose: Port assertions for the standby sequencer.
// Assumes: Bound to the sequencer; one clock domain.
// Notes:   The warm-up bound follows the longest count handed on by the bind.
`timescale 1ns/1ps
`default_nettype none
module sms_standby_sequencer_monitor #(
	parameter int WU_NORM_0 = 16
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic stop_n_pin,
	input wire logic cpu_run,
	input wire logic wdt_run,
	input wire logic periph_clk_en,
	input wire logic tbt_clk_en,
	input wire logic hf_osc_en,
	input wire logic lf_osc_en,
	input wire logic sys_clk_low,
	input wire logic tg_clear,
	input wire logic resume_pulse,
	input wire logic irq_service,
	input wire logic chip_reset
);
	logic [19:0] wu_cnt_ff;
	logic [19:0] nxt_wu_cnt;
	// Counts cycles spent warming up, so an endless warm-up shows.
	assign nxt_wu_cnt = (chip_reset || tbt_clk_en || !(hf_osc_en || lf_osc_en)) ? 20'h0_0000
		: wu_cnt_ff + 20'h0_0001;
	always_ff @(posedge clk) begin
		wu_cnt_ff <= nxt_wu_cnt;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (chip_reset);
	chk_idle_hold: assert property (periph_clk_en && !cpu_run |-> !wdt_run && tbt_clk_en)
		else $error("idle halts the wrong clocks");
	chk_idle0_gate: assert property (tbt_clk_en && !periph_clk_en |-> !cpu_run && !wdt_run)
		else $error("idle0 leaves the cpu running");
	chk_wake_edge: assert property (!tbt_clk_en && !hf_osc_en && !lf_osc_en && $rose(stop_n_pin)
		|-> ##[2:6] (hf_osc_en || lf_osc_en)) else $error("stop pin edge ignored");
	chk_tg_clear: assert property ($rose(hf_osc_en || lf_osc_en) && !tbt_clk_en
		|-> ##[0:2] tg_clear) else $error("timing generator not cleared");
	chk_warm_gate: assert property (tg_clear |=> !cpu_run [*3])
		else $error("cpu released during warm-up");
	chk_wu_bound: assert property (wu_cnt_ff <= 2 * WU_NORM_0 + 3)
		else $error("warm-up overran");
	chk_resume_run: assert property (resume_pulse |-> ##[0:1] cpu_run ##1 !resume_pulse)
		else $error("resume without run");
	chk_svc_run: assert property (irq_service |-> cpu_run ##1 !irq_service)
		else $error("service while halted");
	chk_reset_up: assert property ($fell(chip_reset)
		|-> cpu_run && hf_osc_en && !lf_osc_en && !sys_clk_low) else $error("bad reset mode");
	cover property (resume_pulse && sys_clk_low);
	cover property (irq_service);
	cover property (tbt_clk_en && !periph_clk_en);
endmodule
bind sms_standby_sequencer sms_standby_sequencer_monitor #(.WU_NORM_0(WU_NORM_0)) u_mon (
	.clk, .srst, .stop_n_pin, .cpu_run, .wdt_run, .periph_clk_en, .tbt_clk_en, .hf_osc_en,
	.lf_osc_en, .sys_clk_low, .tg_clear, .resume_pulse, .irq_service, .chip_reset);
`default_nettype wire

// [testbench/sms_pin_model.sv]
// Purpose: Pins outside the sequencer: stop, reset and time base source.
// Assumes: Pins change just after a rising clk edge.
// Notes:   The time base source moves only on command, so idle0 exits are placed.
`timescale 1ns/1ps
`default_nettype none
module sms_pin_model (
	input  wire logic clk,
	output logic      stop_n_pin,
	output logic      reset_n_pin,
	output logic      tb_src_clk_pin
);
	initial begin
		stop_n_pin = 1'b1;
		reset_n_pin = 1'b1;
		tb_src_clk_pin = 1'b1;
	end
	// Low long enough to pass the synchroniser, then the waking rise.
	task automatic stop_pulse();
		@(posedge clk);
		stop_n_pin <= 1'b0;
		repeat (4) @(posedge clk);
		stop_n_pin <= 1'b1;
	endtask
	task automatic set_tb(input logic v);
		@(posedge clk);
		tb_src_clk_pin <= v;
	endtask
	task automatic set_rst(input logic v);
		@(posedge clk);
		reset_n_pin <= v;
	endtask
endmodule
`default_nettype wire

// [testbench/test_standby_mode_sequencer.sv]
// Purpose: Self-checking bench for the standby sequencer.
// Assumes: Small warm-up counts stand in for the long ones.
// Notes:   Software order of enables is kept by the stimulus itself.
`timescale 1ns/1ps
`default_nettype none
module test_standby_mode_sequencer;
	localparam int NC[4] = '{16, 8, 6, 4};
	localparam int SC[4] = '{12, 8, 6, 4};
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata, rd;
	logic [15:0] irq_req = 16'h0000;
	logic        wdt_irq = 1'b0;
	logic        avs_waitrequest, stop_n_pin, reset_n_pin, tb_src_clk_pin, cpu_run, wdt_run;
	logic        periph_clk_en, tbt_clk_en, hf_osc_en, lf_osc_en, sys_clk_low, tg_clear;
	logic        resume_pulse, irq_service, chip_reset, sl, du, dv;
	logic [1:0]  c;
	logic [4:0]  sigs;
	int          n_errors = 0;
	int          total_checks = 0;
	int          i, m, k;
	assign sigs = {tg_clear, chip_reset, irq_service, resume_pulse, cpu_run};
	always #10 clk = ~clk;
	sms_pin_model u_sms_pin_model (.clk, .stop_n_pin, .reset_n_pin, .tb_src_clk_pin);
	sms_standby_sequencer #(.WU_NORM_0(NC[0]), .WU_NORM_1(NC[1]), .WU_NORM_2(NC[2]),
		.WU_NORM_3(NC[3]), .WU_SLOW_0(SC[0]), .WU_SLOW_1(SC[1]), .WU_SLOW_2(SC[2]),
		.WU_SLOW_3(SC[3])) u_sms_standby_sequencer (.clk, .srst, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .stop_n_pin, .reset_n_pin,
		.tb_src_clk_pin, .irq_req, .wdt_irq, .cpu_run, .wdt_run, .periph_clk_en, .tbt_clk_en,
		.hf_osc_en, .lf_osc_en, .sys_clk_low, .tg_clear, .resume_pulse, .irq_service, .chip_reset);
	task tally_and_finish();
		if (n_errors == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task chk_rng(input string nm, input int lo, input int hi, input int g);
		total_checks++;
		if (g < lo || g > hi) begin
			n_errors++;
			$display("ERROR %s expected %0d to %0d seen %0d", nm, lo, hi, g);
		end
	endtask
	// Holds the request until waitrequest is sampled low, then idles one cycle.
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int j;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= ~w;
		j = 0;
		do begin
			@(posedge clk);
			j++;
		end while (avs_waitrequest !== 1'b0 && j < 20);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
		if (j >= 20) begin
			chk("waitrequest", 32'h0000_0000, 32'h0000_0001);
			tally_and_finish();
		end
	endtask
	task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(nm, e, rd & mk);
	endtask
	task wait_for(input int s, input logic v);
		int j;
		j = 0;
		do begin
			@(posedge clk);
			j++;
		end while (sigs[s] !== v && j < 400);
		if (j >= 400) begin
			chk("wait", 32'(v), 32'(~v));
			tally_and_finish();
		end
	endtask
	function automatic int wu_exp(input logic [1:0] cc, input logic d, input logic s);
		return s ? SC[cc] : NC[cc] << d;
	endfunction
	task stop_run();
		int n;
		bus(1'b1, 8'h00, {24'h00_0000, 4'h8, c, 1'b0, dv});
		wait_for(0, 1'b0);
		repeat (3) @(posedge clk);
		chk("stop_osc", 32'h0000_0000, {hf_osc_en, lf_osc_en});
		u_sms_pin_model.stop_pulse();
		wait_for(4, 1'b1);
		chk("wake_osc", {~sl, sl | du}, {hf_osc_en, lf_osc_en});
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (cpu_run !== 1'b1 && n < 400);
		chk_rng("warmup", wu_exp(c, dv, sl) + 1, wu_exp(c, dv, sl) + 2, n);
		if (n >= 400)
			tally_and_finish();
		rd_chk("ctl1", 8'h00, 32'h0000_008d, {c, 1'b0, dv});
		chk("sysck", sl, sys_clk_low);
	endtask
	initial begin
		void'($urandom(79671));
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		chk("rst_mode", 32'h0000_000c, {cpu_run, hf_osc_en, lf_osc_en, sys_clk_low});
		rd_chk("ctl2", 8'h04, 32'h0000_00f4, 32'h0000_0080);
		rd_chk("hole", 8'h40, 32'hffff_ffff, 32'h0000_0000);
		bus(1'b1, 8'h0c, 32'h0000_0000);
		for (i = 0; i < 6; i++) begin
			sl = (i == 4);
			du = (i == 5);
			c = (i < 4) ? i[1:0] : 2'($urandom_range(0, 3));
			dv = 1'($urandom_range(0, 1));
			if (i >= 4)
				bus(1'b1, 8'h04, sl ? 32'h0000_0060 : 32'h0000_00c0);
			stop_run();
		end
		k = $urandom_range(0, 15);
		for (m = 0; m < 2; m++) begin
			bus(1'b1, 8'h10, 32'h0000_0000);
			bus(1'b1, 8'h14, 32'h0000_0001 << k);
			bus(1'b1, 8'h10, m);
			bus(1'b1, 8'h04, 32'h0000_0090);
			chk("idle", 32'h0000_0002, {cpu_run, periph_clk_en, wdt_run});
			irq_req[k] <= 1'b1;
			@(posedge clk);
			irq_req[k] <= 1'b0;
			wait_for(1, 1'b1);
			chk("svc", m, irq_service);
			rd_chk("idle_bit", 8'h04, 32'h0000_0010, 32'h0000_0000);
			bus(1'b1, 8'h18, 32'h0000_0001 << k);
			rd_chk("latch", 8'h18, 32'h0000_ffff, 32'h0000_0000);
		end
		wdt_irq <= 1'b1;
		bus(1'b1, 8'h04, 32'h0000_0090);
		chk("wdt_svc", 32'h0000_0001, irq_service);
		wdt_irq <= 1'b0;
		rd_chk("wdt_state", 8'h1c, 32'h0000_0007, 32'h0000_0000);
		bus(1'b1, 8'h14, 32'h0000_0100);
		for (m = 1; m >= 0; m--) begin
			u_sms_pin_model.set_tb(1'b1);
			bus(1'b1, 8'h08, m << 3);
			bus(1'b1, 8'h10, m);
			bus(1'b1, 8'h04, 32'h0000_0084);
			chk("idle0", 32'h0000_0001, {cpu_run, periph_clk_en, tbt_clk_en});
			u_sms_pin_model.set_tb(1'b0);
			wait_for(1, 1'b1);
			chk("tb_svc", m, irq_service);
			rd_chk("halt", 8'h04, 32'h0000_0004, 32'h0000_0000);
			rd_chk("tb_latch", 8'h18, 32'h0000_0100, m << 8);
			bus(1'b1, 8'h18, 32'h0000_0100);
		end
		for (m = 0; m < 2; m++) begin
			bus(1'b1, m ? 8'h04 : 8'h00, m ? 32'h0000_0090 : 32'h0000_0080);
			wait_for(0, 1'b0);
			u_sms_pin_model.set_rst(1'b0);
			wait_for(3, 1'b1);
			u_sms_pin_model.set_rst(1'b1);
			wait_for(3, 1'b0);
			chk("pin_rst", 32'h0000_000c, {cpu_run, hf_osc_en, lf_osc_en, sys_clk_low});
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
